// *** src/deac_byte_array.sv ***
// byte-wide nonvolatile array model held in flip-flops.
// assumes one write strobe per completed write and a combinational read.
`timescale 1ns/1ps
`default_nettype none

module deac_byte_array
  import deac_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [DEPTH];

  // ****************************************
  // storage cells
  // ****************************************
  // erase and program collapse into one store at the end of the timed cycle
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= ERASED_BYTE;
      end else if (we && (waddr == ADDR_W'(i))) begin
        mem[i] <= wdata; // R15
      end
    end
  end

  // read port, indexed by the address register
  assign rdata = mem[raddr]; // R2

endmodule

`default_nettype wire

// *** src/deac_pkg.sv ***
// package for the data eeprom access controller: register map, field
// positions, timing counts and the state carriers.
// assumes a 50 MHz pclk and an apb slave with 8-bit byte addresses.
//
// Behaviour
// R1: reset during write leaves abort flag set
// R2: 8-bit address selects one of 256 bytes
// R3: bit 7 picks data array or program flash
// R4: bit 6 routes operations to configuration space
// R5: write permit clear after power-up inhibits writes
// R6: abort flag set at start, cleared at finish
// R7: write start settable only, hardware clears it
// R8: completion sets done flag until software clears
// R9: read start ignored when flash or config selected
// R10: read completes in one cycle, bit cleared
// R11: data register holds read byte until overwritten
// R12: unlock key port has no storage, reads zero
// R13: row erase bit makes next write erase block
// R14: abort keeps both space select bits unchanged
// R15: byte write erases then programs, self-timed
// R16: flash writes also need the unlock sequence
// R17: control bits reset as documented, bit 5 zero
// R18: software loads address, clears select, sets read
// R19: write needs 55h then 0AAh then write start
// R20: write start needs permit set beforehand
// R21: control, address, data frozen during write
// R22: data array writes blocked during power-up timer
// R23: write duration is a parameterised cycle counter

package deac_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] KEY_OFF    = 8'h04;
  localparam logic [7:0] ADDR_OFF   = 8'h08;
  localparam logic [7:0] DATA_OFF   = 8'h0C;
  localparam logic [7:0] IRQF_OFF   = 8'h10;
  localparam logic [7:0] IRQE_OFF   = 8'h14;
  localparam logic [7:0] IRQP_OFF   = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CB_PSEL    = 7;
  localparam int CB_CFG     = 6;
  localparam int CB_ERASE   = 4;
  localparam int CB_ABORT   = 3;
  localparam int CB_PERMIT  = 2;
  localparam int CB_WR      = 1;
  localparam int CB_RD      = 0;
  localparam int IRQ_BIT    = 4;

  // ****************************************
  // widths, keys and reset values
  // ****************************************
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int DEPTH      = 256;
  localparam int TPTR_W     = 22;
  localparam int WCNT_W     = 18;
  localparam int PCNT_W     = 12;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ       = 50;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
  localparam int PWRT_TIME_US  = 64;
  localparam int PWRT_CYCLES   = PWRT_TIME_US * CLK_MHZ;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} deac_key_t;
  typedef enum logic [1:0] {TGT_DATA, TGT_FLASH, TGT_CONFIG} deac_target_t;

  typedef struct packed {
    logic psel;
    logic cfg;
    logic erase;
    logic abort;
    logic permit;
    logic wr;
    logic rd;
  } deac_ctrl_t;

  typedef struct packed {
    logic              start;
    logic              row_erase;
    logic              cfg_space;
    logic [TPTR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } deac_flash_req_t;

  typedef struct packed {
    deac_ctrl_t        ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    deac_key_t         key;
    logic              busy;
    deac_target_t      tgt;
    logic [WCNT_W-1:0] wcnt;
    logic [PCNT_W-1:0] pcnt;
    logic              pwrt_done;
    logic              done_flag;
    logic              irq_en;
    logic              irq_pri;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    deac_flash_req_t   freq;
  } deac_state_t;

  // target space from the two select bits, config wins
  function automatic deac_target_t deac_target_of(input logic psel, input logic cfg);
    if (cfg) begin
      return TGT_CONFIG;
    end
    return psel ? TGT_FLASH : TGT_DATA;
  endfunction

endpackage

// *** src/deac_top.sv ***
// data eeprom access controller: apb register slave, unlock sequencing,
// self-timed write engine and request port toward program flash.
// assumes synchronous one-cycle reset pulses for master clear and watchdog,
// and an outside flash engine that follows the request port.
`timescale 1ns/1ps
`default_nettype none

module deac_top
  import deac_pkg::*;
#(
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter int PWRT_CNT  = PWRT_CYCLES
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              master_clear_reset,
  input  wire logic              watchdog_timer_reset,
  input  wire logic [TPTR_W-1:0] table_pointer,
  output logic                   write_done_flag,
  output logic                   write_done_enable,
  output logic                   write_done_priority,
  output logic                   write_busy,
  output deac_flash_req_t        flash_req
);

  // ****************************************
  // state
  // ****************************************
  // one struct holds all state, so reset,
  // soft reset and the write freeze act
  // on a single copy
  deac_state_t       s_reg;
  deac_state_t       s_next;
  logic [DATA_W-1:0] arr_rdata;
  logic              arr_we;

  // ****************************************
  // address decode helper
  // ****************************************
  // a decode used by the error answer only; the read mux decodes paddr itself
  // unmapped offsets answer pslverr, read
  // zero; writes break a key sequence
  function automatic logic deac_mapped(input logic [7:0] a);
    case (a)
      CTRL_OFF, KEY_OFF, ADDR_OFF, DATA_OFF, IRQF_OFF, IRQE_OFF, IRQP_OFF: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // read view of the control register, bit 5 reads zero
  function automatic logic [7:0] deac_ctrl_view(input deac_ctrl_t c);
    logic [7:0] v;
    v           = 8'h00;
    v[CB_PSEL]  = c.psel;
    v[CB_CFG]   = c.cfg;
    v[CB_ERASE] = c.erase;
    v[CB_ABORT] = c.abort;
    v[CB_PERMIT]= c.permit;
    v[CB_WR]    = c.wr;
    v[CB_RD]    = c.rd;
    return v;
  endfunction

  // ****************************************
  // array instance
  // ****************************************
  // reads and writes use the address
  // register, frozen while busy, so the
  // store at expiry cannot move
  deac_byte_array u_array (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (arr_we),
    .waddr   (s_reg.addr),
    .wdata   (s_reg.data),
    .raddr   (s_reg.addr),
    .rdata   (arr_rdata)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  logic              apb_setup_done;
  logic              apb_done;
  logic              wr_op;
  logic              soft_rst;
  logic              finish;
  logic [7:0]        wbyte;
  logic [31:0]       rword;
  deac_target_t      new_tgt;
  logic              can_start;

  // write strobe to the array: timer expiry on a data target only
  // a soft reset on the expiry cycle
  // cancels the store
  assign arr_we = s_reg.busy && (s_reg.tgt == TGT_DATA) && finish && !soft_rst; // R15

  // timer expiry, counted from the start of the write
  // counter is zero after the accepting
  // edge, so busy lasts WRITE_CNT cycles;
  // no slower clock needed
  assign finish = s_reg.busy && (s_reg.wcnt == WCNT_W'(WRITE_CNT - 1)); // R23

  always_comb begin
    s_next         = s_reg;
    apb_setup_done = psel && penable && !s_reg.pready;
    apb_done       = psel && penable && s_reg.pready;
    wr_op          = apb_done && pwrite;
    soft_rst       = master_clear_reset || watchdog_timer_reset;
    wbyte          = pwdata[7:0];
    rword          = 32'h0000_0000;
    new_tgt        = deac_target_of(wbyte[CB_PSEL], wbyte[CB_CFG]);
    can_start      = 1'b0;

    s_next.freq.start = 1'b0;

    // apb answer: one wait cycle, data and error ready with pready
    // fixed two-cycle access keeps prdata
    // registered, no array-to-bus path;
    // costs one cycle per transfer
    s_next.pready  = apb_setup_done;
    s_next.pslverr = apb_setup_done && !deac_mapped(paddr);
    case (paddr)
      CTRL_OFF: begin
        rword[7:0] = deac_ctrl_view(s_reg.ctrl);
      end
      KEY_OFF: begin
        rword = 32'h0000_0000; // R12
      end
      ADDR_OFF: begin
        rword[7:0] = s_reg.addr;
      end
      DATA_OFF: begin
        rword[7:0] = s_reg.data;
      end
      IRQF_OFF: begin
        rword[IRQ_BIT] = s_reg.done_flag;
      end
      IRQE_OFF: begin
        rword[IRQ_BIT] = s_reg.irq_en;
      end
      IRQP_OFF: begin
        rword[IRQ_BIT] = s_reg.irq_pri;
      end
      default: begin
        rword = 32'h0000_0000;
      end
    endcase
    // zero outside the answer cycle
    s_next.prdata = apb_setup_done ? rword : 32'h0000_0000;

    // power-up timer: data array writes refused until it runs out
    // runs once after presetn only; flash
    // and config are not gated by it
    if (!s_reg.pwrt_done) begin
      s_next.pcnt = s_reg.pcnt + PCNT_W'(1);
      if (s_reg.pcnt == PCNT_W'(PWRT_CNT - 1)) begin
        s_next.pwrt_done = 1'b1;
      end
    end

    // a read started last cycle lands in the data register now
    // byte taken at the address as it
    // stands; the read clears in one cycle
    if (s_reg.ctrl.rd) begin
      s_next.data    = arr_rdata; // R10
      s_next.ctrl.rd = 1'b0; // R10
    end

    // self-timed write engine
    // one counter times every target; erase
    // and program fold into one store
    if (s_reg.busy) begin
      s_next.wcnt = s_reg.wcnt + WCNT_W'(1); // R23
      if (finish) begin
        s_next.busy       = 1'b0;
        s_next.wcnt       = '0;
        s_next.ctrl.wr    = 1'b0; // R7
        s_next.ctrl.abort = 1'b0; // R6
        if (s_reg.tgt != TGT_DATA) begin
          s_next.ctrl.erase = 1'b0; // R13
        end
      end
    end

    // ****************************************
    // register writes
    // ****************************************
    // acts only on the pready edge, so a
    // stalled master applies nothing twice
    if (wr_op) begin
      // any write other than to the key port breaks the unlock order
      if (paddr != KEY_OFF) begin
        s_next.key = KEY_IDLE; // R19
      end
      case (paddr)
        CTRL_OFF: begin
          if (!s_reg.busy) begin // R21
            s_next.ctrl.psel   = wbyte[CB_PSEL]; // R3
            s_next.ctrl.cfg    = wbyte[CB_CFG]; // R4
            s_next.ctrl.erase  = wbyte[CB_ERASE]; // R13
            s_next.ctrl.permit = wbyte[CB_PERMIT]; // R5
            // read start only on the data array
            if (wbyte[CB_RD] && (new_tgt == TGT_DATA)) begin // R9
              s_next.ctrl.rd = 1'b1; // R10
            end
            // write start: needs permit from an earlier write and the key
            // old permit, not the new byte: one
            // write cannot both permit and start;
            // power-up gate holds data targets only
            can_start = s_reg.ctrl.permit && (s_reg.key == KEY_ARMED) &&
                        ((new_tgt != TGT_DATA) || s_reg.pwrt_done);
            if (wbyte[CB_WR]) begin // R7
              if (can_start) begin // R16 R19 R20 R22
                s_next.ctrl.wr    = 1'b1;
                s_next.ctrl.abort = 1'b1; // R6
                s_next.busy       = 1'b1; // R23
                s_next.wcnt       = '0;
                s_next.tgt        = new_tgt;
                // pointer and data as they stand;
                // the flash engine latches on start
                if (new_tgt != TGT_DATA) begin
                  s_next.freq.start     = 1'b1; // R3
                  s_next.freq.cfg_space = (new_tgt == TGT_CONFIG); // R4
                  s_next.freq.row_erase = wbyte[CB_ERASE]; // R13
                  s_next.freq.addr      = table_pointer;
                  s_next.freq.data      = s_reg.data;
                end
              end else if (s_reg.ctrl.permit) begin
                // improper attempt with permit set is flagged
                s_next.ctrl.abort = 1'b1;
              end
            end
          end
        end
        KEY_OFF: begin
          // the key port keeps no value, only the sequence position
          // a wrong byte drops to idle; 55h
          // always restarts the sequence
          if (wbyte == KEY_FIRST) begin
            s_next.key = KEY_GOT_FIRST; // R19
          end else if ((wbyte == KEY_SECOND) && (s_reg.key == KEY_GOT_FIRST)) begin
            s_next.key = KEY_ARMED; // R19
          end else begin
            s_next.key = KEY_IDLE; // R19
          end
        end
        ADDR_OFF: begin
          if (!s_reg.busy) begin // R21
            s_next.addr = wbyte; // R2
          end
        end
        DATA_OFF: begin
          if (!s_reg.busy) begin // R21
            s_next.data = wbyte; // R11
          end
        end
        // only bit 4 lives here; the other
        // bits belong to other blocks
        IRQF_OFF: begin
          s_next.done_flag = wbyte[IRQ_BIT]; // R8
        end
        IRQE_OFF: begin
          s_next.irq_en = wbyte[IRQ_BIT];
        end
        IRQP_OFF: begin
          s_next.irq_pri = wbyte[IRQ_BIT];
        end
        default: begin
          s_next.key = KEY_IDLE;
        end
      endcase
    end

    // enable and priority are plain bits
    // for the outside interrupt controller
    // completion sets the done flag; placed after the register writes so a set beats a clear
    if (finish && !soft_rst) begin
      s_next.done_flag = 1'b1; // R8
    end

    // ****************************************
    // master clear and watchdog reset
    // ****************************************
    // applied last, so it beats any control
    // or key write or start in the same cycle
    // the abort flag and both select bits are left as they are, so a cut
    // write stays visible and its target traceable
    if (soft_rst) begin
      s_next.busy        = 1'b0;
      s_next.wcnt        = '0;
      s_next.key         = KEY_IDLE;
      s_next.ctrl.wr     = 1'b0; // R17
      s_next.ctrl.rd     = 1'b0; // R17
      s_next.ctrl.erase  = 1'b0; // R17
      s_next.ctrl.permit = 1'b0; // R17
      s_next.ctrl.abort  = s_reg.ctrl.abort; // R1
      s_next.ctrl.psel   = s_reg.ctrl.psel; // R14
      s_next.ctrl.cfg    = s_reg.ctrl.cfg; // R14
      s_next.freq.start  = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // undefined power-on bits come up as zero here
  // presetn also restarts the power-up timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0; // R5 R17
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs, all straight from the state register
  // ****************************************
  // no logic between state and pins:
  // outputs are glitch free
  assign prdata              = s_reg.prdata;
  assign pready              = s_reg.pready;
  assign pslverr             = s_reg.pslverr;
  assign write_done_flag     = s_reg.done_flag;
  assign write_done_enable   = s_reg.irq_en;
  assign write_done_priority = s_reg.irq_pri;
  assign write_busy          = s_reg.busy;
  assign flash_req           = s_reg.freq;

endmodule

`default_nettype wire

// *** tb/deac_props.sv ***
// checker: apb answers, write timing and done flag of the controller
// assumes a bind into deac_top, one clock, presetn clearing all state
`timescale 1ns/1ps
`default_nettype none

module deac_props
  import deac_pkg::*;
#(
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter int PWRT_CNT  = PWRT_CYCLES
)
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            master_clear_reset,
  input wire logic            watchdog_timer_reset,
  input wire logic            write_done_flag,
  input wire logic            write_busy,
  input wire deac_flash_req_t flash_req
);
  // ****************
  // helpers
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] bcnt_reg;
  logic        rd_acc;
  logic        mapped;
  logic        done_clr;

  // apb qualifiers decoded once
  assign rd_acc   = psel && penable && pready && !pwrite;
  assign mapped   = paddr <= IRQP_OFF && paddr[1:0] == 2'b00;
  assign done_clr = psel && penable && pready && pwrite && paddr == IRQF_OFF && !pwdata[IRQ_BIT];

  // busy run length; a stuck timer shows up as an overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_reg <= '0;
    end else begin
      bcnt_reg <= write_busy ? bcnt_reg + 32'd1 : '0;
    end
  end

  // ****************
  // properties
  // ****************
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_pulse; pready ##1 !pready; endsequence
  property p_answer; s_wait |=> s_pulse; endproperty
  property p_nulls; rd_acc && (paddr == KEY_OFF || !mapped) |-> prdata == 32'h0000_0000 && pslverr == !mapped;
  endproperty
  property p_rsvd; rd_acc && paddr == CTRL_OFF |-> prdata[31:8] == 24'h00_0000 && !prdata[5]; endproperty
  property p_busy_len;
    $fell(write_busy) && !$past(master_clear_reset) && !$past(watchdog_timer_reset)
      |-> $past(bcnt_reg) >= WRITE_CNT - 1 && $past(bcnt_reg) <= WRITE_CNT + 1;
  endproperty
  property p_busy_max; write_busy |-> bcnt_reg <= WRITE_CNT + 1; endproperty
  property p_done_end; $rose(write_done_flag) |-> $fell(write_busy); endproperty
  property p_done_hold; write_done_flag && !done_clr |=> write_done_flag; endproperty
  property p_soft; write_busy && (master_clear_reset || watchdog_timer_reset)
    |=> !write_busy && !$rose(write_done_flag); endproperty
  property p_start; flash_req.start |-> write_busy ##1 !flash_req.start; endproperty

  a_answer: assert property (p_answer)
    else $error("pready not a single pulse after access");
  a_nulls: assert property (p_nulls)
    else $error("key port or unmapped read wrong");
  a_rsvd: assert property (p_rsvd)
    else $error("control reserved bits not zero");
  a_busy_len: assert property (p_busy_len)
    else $error("write time off");
  a_busy_max: assert property (p_busy_max)
    else $error("write overruns its timer");
  a_done_end: assert property (p_done_end)
    else $error("done flag without write end");
  a_done_hold: assert property (p_done_hold)
    else $error("done flag dropped on its own");
  a_soft: assert property (p_soft)
    else $error("soft reset did not stop write");
  a_start: assert property (p_start)
    else $error("flash start pulse wrong");
endmodule

bind deac_top deac_props #(.WRITE_CNT(WRITE_CNT), .PWRT_CNT(PWRT_CNT)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .master_clear_reset(master_clear_reset), .watchdog_timer_reset(watchdog_timer_reset),
  .write_done_flag(write_done_flag), .write_busy(write_busy), .flash_req(flash_req)
);
`default_nettype wire

// *** tb/deac_top_bench.sv ***
// self-checking bench for deac_top with a byte-array model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none

module deac_top_bench
  import deac_pkg::*;
();
  localparam int WC = 60;
  localparam int PC = 60;
  logic              pclk, presetn, psel, penable, pwrite, mcr, wdr;
  logic              pready, pslverr, rerr, dflag, den, dpri, busy;
  logic [7:0]        paddr, a, d, c;
  logic [31:0]       pwdata, prdata, rdat;
  logic [TPTR_W-1:0] tptr;
  deac_flash_req_t   freq, cap;
  logic [7:0]        mem [DEPTH];
  int                failures = 0, cmp_count = 0, seed = 8183, starts = 0, s0;

  deac_top #(.WRITE_CNT(WC), .PWRT_CNT(PC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_reset(mcr), .watchdog_timer_reset(wdr), .table_pointer(tptr),
    .write_done_flag(dflag), .write_done_enable(den), .write_done_priority(dpri),
    .write_busy(busy), .flash_req(freq)
  );

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // catch the one-cycle flash start pulse
  always @(posedge pclk) begin
    if (freq.start === 1'b1) begin
      cap <= freq;
      starts <= starts + 1;
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      close_out();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 0);
    chk($sformatf("reg %h", ad), rdat, exp);
    chk("slverr", rerr, 1'b0);
  endtask

  task automatic keyseq();
    wr(KEY_OFF, KEY_FIRST);
    wr(KEY_OFF, KEY_SECOND);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WC + 10) begin
      @(posedge pclk);
      k++;
    end
    if (k >= WC + 10) begin
      failures++;
      close_out();
    end
  endtask

  // byte write; the frozen registers are poked while the timer runs
  task automatic dwr(input logic [7:0] ad, input logic [7:0] dd);
    wr(ADDR_OFF, ad);
    wr(DATA_OFF, dd);
    wr(CTRL_OFF, 8'h04);
    keyseq();
    wr(CTRL_OFF, 8'h06);
    chk("busy", busy, 1'b1);
    wr(DATA_OFF, ~dd);
    wr(ADDR_OFF, ~ad);
    wr(CTRL_OFF, 8'h00);
    rd(CTRL_OFF, 8'h0E);
    rd(DATA_OFF, dd);
    rd(ADDR_OFF, ad);
    wait_idle();
    mem[ad] = dd;
    rd(CTRL_OFF, 8'h04);
    chk("done", dflag, 1'b1);
    wr(IRQF_OFF, 8'h00);
    chk("done", dflag, 1'b0);
  endtask

  task automatic dread(input logic [7:0] ad);
    wr(ADDR_OFF, ad);
    wr(CTRL_OFF, 8'h05);
    rd(DATA_OFF, mem[ad]);
    rd(CTRL_OFF, 8'h04);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, mcr, wdr} = '0;
    paddr = '0;
    pwdata = '0;
    tptr = '0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTRL_OFF, 8'h00);
    rd(KEY_OFF, 8'h00);
    rd(IRQF_OFF, 8'h00);
    apb(1'b0, 8'h1C, 0);
    chk("slverr", rerr, 1'b1);
    // still inside the power-up window here
    wr(CTRL_OFF, 8'h06);
    chk("busy", busy, 1'b0);
    rd(CTRL_OFF, 8'h04);
    keyseq();
    wr(CTRL_OFF, 8'h06);
    chk("busy", busy, 1'b0);
    rd(CTRL_OFF, 8'h0C);
    repeat (PC) @(posedge pclk);
    $display("test reset done");
    s0 = starts;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      dwr(a, d);
      dread(a);
    end
    chk("start", starts, s0);
    $display("test data write done");
    // broken key order, then a foreign write inside the sequence
    for (int j = 0; j < 2; j++) begin
      wr(CTRL_OFF, 8'h04);
      wr(KEY_OFF, j ? KEY_FIRST : KEY_SECOND);
      if (j) wr(ADDR_OFF, 8'h00);
      wr(KEY_OFF, j ? KEY_SECOND : KEY_FIRST);
      wr(CTRL_OFF, 8'h06);
      chk("busy", busy, 1'b0);
      rd(CTRL_OFF, 8'h0C);
    end
    // read start refused for flash and config targets
    for (int j = 0; j < 2; j++) begin
      c = j ? 8'h41 : 8'h81;
      wr(DATA_OFF, 8'h5A);
      wr(CTRL_OFF, c);
      apb(1'b0, CTRL_OFF, 0);
      chk("ctrl", rdat & 32'h0000_00F7, c & 8'hF6);
      rd(DATA_OFF, 8'h5A);
    end
    $display("test refusals done");
    // flash then config target, both with row erase
    for (int j = 0; j < 2; j++) begin
      c = j ? 8'hD4 : 8'h94;
      tptr <= 22'($random(seed));
      s0 = starts;
      wr(CTRL_OFF, c);
      wr(CTRL_OFF, c | 8'h02);
      chk("start", starts, s0);
      keyseq();
      wr(CTRL_OFF, c | 8'h02);
      wait_idle();
      chk("start", starts, s0 + 1);
      chk("erase", cap.row_erase, 1'b1);
      chk("config", cap.cfg_space, j);
      chk("fdata", cap.data, 8'h5A);
      chk("tptr", cap.addr, tptr);
      rd(CTRL_OFF, c & 8'hEF);
      wr(IRQF_OFF, 8'h00);
    end
    $display("test flash done");
    // soft resets in mid write
    for (int j = 0; j < 2; j++) begin
      c = j ? 8'hC4 : 8'h84;
      wr(CTRL_OFF, c);
      keyseq();
      wr(CTRL_OFF, c | 8'h02);
      chk("busy", busy, 1'b1);
      mcr <= !j;
      wdr <= j;
      @(posedge pclk);
      mcr <= 1'b0;
      wdr <= 1'b0;
      @(posedge pclk);
      chk("busy", busy, 1'b0);
      rd(CTRL_OFF, c ^ 8'h0C);
      chk("done", dflag, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      wr(j ? IRQP_OFF : IRQE_OFF, 32'hFFFF_FFFF);
      rd(j ? IRQP_OFF : IRQE_OFF, 8'h10);
    end
    chk("irq", {den, dpri}, 2'b11);
    $display("test resets done");
    close_out();
  end
endmodule
`default_nettype wire
